// file: dmac_pkg.sv
// Shared constants and types for the multiply-accumulate block
package dmac_pkg;
	typedef enum logic [1:0] {MODE_SIMPLE, MODE_MAC, MODE_ADD2, MODE_ADD4} dmac_mode_e;
	typedef enum logic [1:0] {SIZE_9, SIZE_18, SIZE_36, SIZE_RSV} dmac_size_e;
	localparam int ROWS = 4;
	localparam int OPW  = 18;
	localparam int ROWW = 36;
	localparam int ACCW = 52;
	localparam int P18W = 38;
	localparam int P9W  = 20;
	localparam int S9W  = 21;
	localparam int AW   = 12;
	localparam int DW   = 32;
	// Register map
	localparam logic [AW-1:0] CONFIG_OFS = 12'h000;
	localparam logic [AW-1:0] STATUS_OFS = 12'h004;
	localparam logic [7:0]    CONFIG_RST = 8'h00;
	localparam int CFG_LO_MODE_POS = 0;
	localparam int CFG_LO_SIZE_POS = 2;
	localparam int CFG_HI_MODE_POS = 4;
	localparam int CFG_HI_SIZE_POS = 6;
	localparam int STAT_SAT_POS     = 0;
	localparam int STAT_LO_MODE_POS = 2;
	localparam int STAT_HI_MODE_POS = 4;
	// Q1.15 rounding and saturation on a Q2.30 product
	localparam logic signed [ACCW-1:0] RND_ADD   = 52'sh0_0000_0000_4000;
	localparam logic signed [ACCW-1:0] FRAC_MASK = 52'shf_ffff_ffff_8000;
	localparam logic signed [ACCW-1:0] SAT_POS   = 52'sh0_0000_3fff_8000;
	localparam logic signed [ACCW-1:0] SAT_NEG   = 52'shf_ffff_c000_0000;
endpackage : dmac_pkg

// file: dmac_row_mult.sv
// One row unit: an 18x18 multiplier that also splits into two 9x9 lanes
`timescale 1ns/100ps
module dmac_row_mult (
	// Operands and signedness
	input  wire logic [dmac_pkg::OPW-1:0]          a_i,
	input  wire logic [dmac_pkg::OPW-1:0]          b_i,
	input  wire logic                              sa_i,
	input  wire logic                              sb_i,
	// Products
	output logic      [dmac_pkg::P18W-1:0]         p18_o,
	output logic      [1:0][dmac_pkg::P9W-1:0]     p9_o
);
	import dmac_pkg::*;

	// One extra sign bit per operand covers signed, unsigned and mixed
	assign p18_o = $signed({sa_i & a_i[OPW-1], a_i}) * $signed({sb_i & b_i[OPW-1], b_i});

	// Two independent 9x9 lanes from the same operand bits
	for (genvar k = 0; k < 2; k++) begin : g_lane
		assign p9_o[k] = $signed({sa_i & a_i[9*k+8], a_i[9*k +: 9]})
			* $signed({sb_i & b_i[9*k+8], b_i[9*k +: 9]});
	end
endmodule : dmac_row_mult

// file: dmac_pair_sum.sv
// Half-block adder, accumulator and Q1.15 round/saturate stage
`timescale 1ns/100ps
module dmac_pair_sum (
	// Clock and reset
	input  wire logic                               clk_i,
	input  wire logic                               rst_n_i,
	// Products of the two rows of this half
	input  wire logic [1:0][dmac_pkg::P18W-1:0]     p18_i,
	input  wire logic [3:0][dmac_pkg::P9W-1:0]      p9_i,
	// Controls
	input  wire dmac_pkg::dmac_mode_e               mode_i,
	input  wire logic                               is9_i,
	input  wire logic                               add_i,
	input  wire logic                               rnd_i,
	input  wire logic                               sat_i,
	input  wire logic                               sload_i,
	input  wire logic                               go_i,
	input  wire logic                               clr_i,
	// Results
	output logic      [1:0][dmac_pkg::ROWW-1:0]     res_o,
	output logic      [dmac_pkg::ACCW-1:0]          sum18_o,
	output logic      [1:0][dmac_pkg::S9W-1:0]      sum9_o,
	output logic                                    sat_hit_o
);
	import dmac_pkg::*;

	typedef struct packed {
		logic signed [ACCW-1:0] acc;
	} dmac_pair_s;

	dmac_pair_s              st_reg;
	dmac_pair_s              st_next;
	logic signed [ACCW-1:0]  p0;
	logic signed [ACCW-1:0]  p1;
	logic signed [ACCW-1:0]  sum18;
	logic signed [ACCW-1:0]  acc_in;
	logic [ACCW:0]           r_acc;
	logic [ACCW:0]           r_p0;
	logic [ACCW:0]           r_p1;
	logic [ACCW:0]           r_sum;

	// Round then clamp; the top bit flags a clamp
	function automatic logic [ACCW:0] rs(input logic signed [ACCW-1:0] v, input logic rnd, input logic sat);
		logic signed [ACCW-1:0] t;
		t = v;
		if (rnd)
			t = (t + RND_ADD) & FRAC_MASK;
		if (sat && t > SAT_POS)
			return {1'b1, SAT_POS};
		if (sat && t < SAT_NEG)
			return {1'b1, SAT_NEG};
		return {1'b0, t};
	endfunction : rs

	// Adder, accumulator and result selection
	always_comb begin
		st_next = st_reg;
		p0 = ACCW'(signed'(p18_i[0]));
		p1 = ACCW'(signed'(p18_i[1]));
		sum18 = add_i ? p0 + p1 : p0 - p1;
		for (int k = 0; k < 2; k++) begin
			sum9_o[k] = add_i ? S9W'(signed'(p9_i[k])) + S9W'(signed'(p9_i[k+2]))
				: S9W'(signed'(p9_i[k])) - S9W'(signed'(p9_i[k+2]));
		end
		acc_in = sload_i ? p0 : (add_i ? st_reg.acc + p0 : st_reg.acc - p0);
		r_acc = rs(acc_in, rnd_i, sat_i);
		r_p0 = rs(p0, rnd_i, sat_i);
		r_p1 = rs(p1, rnd_i, sat_i);
		r_sum = rs(sum18, rnd_i, sat_i);
		sum18_o = sum18;
		// Clear wins over an accumulate in the same cycle
		if (clr_i)
			st_next.acc = '0;
		else if (go_i && mode_i == MODE_MAC)
			st_next.acc = r_acc[ACCW-1:0];
		sat_hit_o = 1'b0;
		case (mode_i)
			MODE_MAC: begin
				res_o[0] = r_acc[ROWW-1:0];
				res_o[1] = ROWW'(signed'(r_acc[ACCW-1:ROWW]));
				sat_hit_o = r_acc[ACCW];
			end
			MODE_ADD2: begin
				if (is9_i) begin
					res_o[0] = ROWW'(signed'(sum9_o[0]));
					res_o[1] = ROWW'(signed'(sum9_o[1]));
				end else begin
					res_o[0] = r_sum[ROWW-1:0];
					res_o[1] = ROWW'(signed'(r_sum[ACCW-1:ROWW]));
					sat_hit_o = r_sum[ACCW];
				end
			end
			default: begin
				if (is9_i) begin
					res_o[0] = {p9_i[1][OPW-1:0], p9_i[0][OPW-1:0]};
					res_o[1] = {p9_i[3][OPW-1:0], p9_i[2][OPW-1:0]};
				end else begin
					res_o[0] = r_p0[ROWW-1:0];
					res_o[1] = r_p1[ROWW-1:0];
					sat_hit_o = r_p0[ACCW] | r_p1[ACCW];
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	acc_load_a: assert property (
		go_i && !clr_i && mode_i == MODE_MAC && sload_i && !rnd_i && !sat_i |=> st_reg.acc == $past(p0)
	) else $error("Sync load did not load the product");

	acc_clear_a: assert property (
		clr_i |=> st_reg.acc == '0 ##1 (st_reg.acc == '0 || $past(go_i))
	) else $error("Accumulator not cleared");
endmodule : dmac_pair_sum

// file: dmac_block.sv
// Top of the multiply-accumulate block: rows, chain, modes and APB registers
`timescale 1ns/100ps
module dmac_block (
	// Clock and reset
	input  wire logic                                          SYS_CLK_I,
	input  wire logic                                          RST_N_I,
	// APB slave
	input  wire logic                                          PSEL_I,
	input  wire logic                                          PENABLE_I,
	input  wire logic                                          PWRITE_I,
	input  wire logic [dmac_pkg::AW-1:0]                       PADDR_I,
	input  wire logic [dmac_pkg::DW-1:0]                       PWDATA_I,
	output logic      [dmac_pkg::DW-1:0]                       PRDATA_O,
	output logic                                               PREADY_O,
	output logic                                               PSLVERR_O,
	// Per-row clock, clear and enable
	input  wire logic [dmac_pkg::ROWS-1:0]                     LANE_CLOCK_I,
	input  wire logic [dmac_pkg::ROWS-1:0]                     LANE_ASYNC_CLEAR_I,
	input  wire logic [dmac_pkg::ROWS-1:0]                     LANE_CLK_ENABLE_I,
	// Control bus
	input  wire logic                                          OPERAND_A_SIGNED_I,
	input  wire logic                                          OPERAND_B_SIGNED_I,
	input  wire logic                                          UNIT_MODE_SEL_LO_I,
	input  wire logic                                          UNIT_MODE_SEL_HI_I,
	input  wire logic                                          ADD_SUB_SEL_LO_I,
	input  wire logic                                          ADD_SUB_SEL_HI_I,
	input  wire logic                                          PAIR_LO_ROUND_I,
	input  wire logic                                          PAIR_LO_SATURATE_I,
	input  wire logic                                          PAIR_HI_ROUND_I,
	input  wire logic                                          PAIR_HI_SATURATE_I,
	input  wire logic                                          ACC_SYNC_LOAD_LO_I,
	input  wire logic                                          ACC_SYNC_LOAD_HI_I,
	input  wire logic [dmac_pkg::ROWS-1:0]                     INPUT_A_SOURCE_SEL_I,
	input  wire logic [dmac_pkg::ROWS-1:0]                     INPUT_B_SOURCE_SEL_I,
	// Operands and shift chain in
	input  wire logic [dmac_pkg::ROWS-1:0][dmac_pkg::OPW-1:0]  OPERAND_A_I,
	input  wire logic [dmac_pkg::ROWS-1:0][dmac_pkg::OPW-1:0]  OPERAND_B_I,
	input  wire logic [dmac_pkg::OPW-1:0]                      CASC_A_I,
	input  wire logic [dmac_pkg::OPW-1:0]                      CASC_B_I,
	// Results and shift chain out
	output logic      [dmac_pkg::ROWS-1:0][dmac_pkg::ROWW-1:0] ROW_RESULT_O,
	output logic      [dmac_pkg::OPW-1:0]                      CASC_A_O,
	output logic      [dmac_pkg::OPW-1:0]                      CASC_B_O
);
	import dmac_pkg::*;

	typedef struct packed {
		logic [7:0]                cfg;
		logic [DW-1:0]             prdata;
		logic [1:0]                sat;
		logic [ROWS-1:0]           clk_s1;
		logic [ROWS-1:0]           clk_s2;
		logic [ROWS-1:0]           clk_s3;
		logic [ROWS-1:0]           clr_s1;
		logic [ROWS-1:0]           clr_s2;
		logic [ROWS-1:0][OPW-1:0]  a;
		logic [ROWS-1:0][OPW-1:0]  b;
		logic [ROWS-1:0][ROWW-1:0] res;
	} dmac_top_s;

	dmac_top_s                    st_reg;
	dmac_top_s                    st_next;
	logic [ROWS-1:0]              tick;
	logic [ROWS-1:0]              row_go;
	logic [ROWS-1:0][OPW-1:0]     chain_a;
	logic [ROWS-1:0][OPW-1:0]     chain_b;
	logic [ROWS-1:0][P18W-1:0]    p18;
	logic [ROWS-1:0][1:0][P9W-1:0] p9;
	logic [ROWW-1:0]              a36;
	logic [ROWW-1:0]              b36;
	logic [2*ROWW+1:0]            p74;
	dmac_size_e                   size_lo;
	dmac_size_e                   size_hi;
	dmac_mode_e                   mode_lo;
	dmac_mode_e                   mode_hi;
	logic                         is36;
	logic                         add4;
	logic [1:0][ROWW-1:0]         res_lo;
	logic [1:0][ROWW-1:0]         res_hi;
	logic [ACCW-1:0]              sum_lo;
	logic [ACCW-1:0]              sum_hi;
	logic [ACCW-1:0]              tot18;
	logic [1:0][S9W-1:0]          s9_lo;
	logic [1:0][S9W-1:0]          s9_hi;
	logic [1:0][S9W-1:0]          tot9;
	logic                         sat_lo;
	logic                         sat_hi;
	logic [ROWS-1:0][ROWW-1:0]    comp;
	logic                         apb_setup;
	logic                         apb_acc;
	logic                         apb_wr;
	logic                         hit;
	logic [DW-1:0]                rd_val;

	// Mode a half really runs once size limits are applied
	function automatic dmac_mode_e eff_mode(input logic sel, input logic [1:0] m, input dmac_size_e s);
		dmac_mode_e e;
		e = dmac_mode_e'(m);
		if (!sel || s == SIZE_36 || s == SIZE_RSV)
			e = MODE_SIMPLE;
		else if (e == MODE_MAC && s != SIZE_18)
			e = MODE_SIMPLE;
		return e;
	endfunction : eff_mode

	// A row steps on the rising edge of its own lane clock, if enabled
	assign tick = st_reg.clk_s2 & ~st_reg.clk_s3;
	assign row_go = tick & LANE_CLK_ENABLE_I;

	// Chain source: row above, or the cascade input for row 0
	always_comb begin
		chain_a[0] = CASC_A_I;
		chain_b[0] = CASC_B_I;
		for (int i = 1; i < ROWS; i++) begin
			chain_a[i] = st_reg.a[i-1];
			chain_b[i] = st_reg.b[i-1];
		end
	end

	// Row multipliers
	for (genvar g = 0; g < ROWS; g++) begin : g_row
		dmac_row_mult u_mult (
			.a_i   (st_reg.a[g]),
			.b_i   (st_reg.b[g]),
			.sa_i  (OPERAND_A_SIGNED_I),
			.sb_i  (OPERAND_B_SIGNED_I),
			.p18_o (p18[g]),
			.p9_o  (p9[g])
		);
	end

	// Full-width product uses rows 1 and 0 as high and low halves
	assign a36 = {st_reg.a[1], st_reg.a[0]};
	assign b36 = {st_reg.b[1], st_reg.b[0]};
	assign p74 = $signed({OPERAND_A_SIGNED_I & a36[ROWW-1], a36})
		* $signed({OPERAND_B_SIGNED_I & b36[ROWW-1], b36});

	// Effective modes per half
	always_comb begin
		size_lo = dmac_size_e'(st_reg.cfg[CFG_LO_SIZE_POS +: 2]);
		size_hi = dmac_size_e'(st_reg.cfg[CFG_HI_SIZE_POS +: 2]);
		is36 = (size_lo == SIZE_36);
		mode_lo = eff_mode(UNIT_MODE_SEL_LO_I, st_reg.cfg[CFG_LO_MODE_POS +: 2], size_lo);
		mode_hi = eff_mode(UNIT_MODE_SEL_HI_I, st_reg.cfg[CFG_HI_MODE_POS +: 2], size_hi);
		// The full-width product owns the whole block
		if (is36 || mode_hi == MODE_ADD4)
			mode_hi = MODE_SIMPLE;
		add4 = (mode_lo == MODE_ADD4);
	end

	// Lower half: rows 0 and 1
	dmac_pair_sum u_lo (
		.clk_i     (SYS_CLK_I),
		.rst_n_i   (RST_N_I),
		.p18_i     (p18[1:0]),
		.p9_i      ({p9[1], p9[0]}),
		.mode_i    (mode_lo),
		.is9_i     (size_lo == SIZE_9),
		.add_i     (ADD_SUB_SEL_LO_I),
		.rnd_i     (PAIR_LO_ROUND_I),
		.sat_i     (PAIR_LO_SATURATE_I),
		.sload_i   (ACC_SYNC_LOAD_LO_I),
		.go_i      (row_go[0]),
		.clr_i     (st_reg.clr_s2[0]),
		.res_o     (res_lo),
		.sum18_o   (sum_lo),
		.sum9_o    (s9_lo),
		.sat_hit_o (sat_lo)
	);

	// Upper half: rows 2 and 3
	dmac_pair_sum u_hi (
		.clk_i     (SYS_CLK_I),
		.rst_n_i   (RST_N_I),
		.p18_i     (p18[3:2]),
		.p9_i      ({p9[3], p9[2]}),
		.mode_i    (mode_hi),
		.is9_i     (size_hi == SIZE_9),
		.add_i     (ADD_SUB_SEL_HI_I),
		.rnd_i     (PAIR_HI_ROUND_I),
		.sat_i     (PAIR_HI_SATURATE_I),
		.sload_i   (ACC_SYNC_LOAD_HI_I),
		.go_i      (row_go[2]),
		.clr_i     (st_reg.clr_s2[2]),
		.res_o     (res_hi),
		.sum18_o   (sum_hi),
		.sum9_o    (s9_hi),
		.sat_hit_o (sat_hi)
	);

	// Compose row results; four-multiplier sums land on rows 0 and 1
	always_comb begin
		tot18 = sum_lo + sum_hi;
		for (int k = 0; k < 2; k++) begin
			tot9[k] = s9_lo[k] + s9_hi[k];
		end
		comp = {res_hi, res_lo};
		if (is36) begin
			comp = {{2*ROWW{1'b0}}, p74[2*ROWW-1:0]};
		end else if (add4) begin
			if (size_lo == SIZE_9)
				comp = {{2*ROWW{1'b0}}, ROWW'(signed'(tot9[1])), ROWW'(signed'(tot9[0]))};
			else
				comp = {{2*ROWW{1'b0}}, ROWW'(signed'(tot18[ACCW-1:ROWW])), tot18[ROWW-1:0]};
		end
	end

	// APB decode; the slave always answers in the access cycle
	assign apb_setup = PSEL_I & ~PENABLE_I;
	assign apb_acc = PSEL_I & PENABLE_I;
	assign hit = (PADDR_I == CONFIG_OFS) || (PADDR_I == STATUS_OFS);
	assign apb_wr = apb_acc & PWRITE_I & (PADDR_I == CONFIG_OFS);
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = apb_acc & ~hit;
	assign PRDATA_O = st_reg.prdata;

	// Read mux, sampled in the setup cycle so read data comes from a flop
	always_comb begin
		rd_val = '0;
		case (PADDR_I)
			CONFIG_OFS: rd_val[7:0] = st_reg.cfg;
			STATUS_OFS: begin
				rd_val[STAT_SAT_POS +: 2] = st_reg.sat;
				rd_val[STAT_LO_MODE_POS +: 2] = mode_lo;
				rd_val[STAT_HI_MODE_POS +: 2] = mode_hi;
			end
			default: rd_val = '0;
		endcase
	end

	// Next state
	always_comb begin
		st_next = st_reg;
		// Lane clock and clear come from another domain: two flops first
		st_next.clk_s1 = LANE_CLOCK_I;
		st_next.clk_s2 = st_reg.clk_s1;
		st_next.clk_s3 = st_reg.clk_s2;
		st_next.clr_s1 = LANE_ASYNC_CLEAR_I;
		st_next.clr_s2 = st_reg.clr_s1;
		st_next.sat = {sat_hi, sat_lo};
		if (apb_setup && !PWRITE_I)
			st_next.prdata = rd_val;
		if (apb_wr)
			st_next.cfg = PWDATA_I[7:0];
		for (int i = 0; i < ROWS; i++) begin
			// Clear has priority over a step in the same cycle
			if (st_reg.clr_s2[i]) begin
				st_next.a[i] = '0;
				st_next.b[i] = '0;
				st_next.res[i] = '0;
			end else if (row_go[i]) begin
				st_next.a[i] = INPUT_A_SOURCE_SEL_I[i] ? chain_a[i] : OPERAND_A_I[i];
				st_next.b[i] = INPUT_B_SOURCE_SEL_I[i] ? chain_b[i] : OPERAND_B_I[i];
				st_next.res[i] = comp[i];
			end
		end
	end

	// State register, synchronous reset
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			st_reg <= '0;
			st_reg.cfg <= CONFIG_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flops; bottom row feeds the next block
	assign ROW_RESULT_O = st_reg.res;
	assign CASC_A_O = st_reg.a[ROWS-1];
	assign CASC_B_O = st_reg.b[ROWS-1];

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);

	shift_chain_a: assert property (
		row_go[1] && !st_reg.clr_s2[1] && INPUT_A_SOURCE_SEL_I[1] |=> st_reg.a[1] == $past(st_reg.a[0])
	) else $error("Row 1 did not shift from row 0");

	cascade_in_a: assert property (
		row_go[0] && !st_reg.clr_s2[0] && INPUT_B_SOURCE_SEL_I[0] |=> st_reg.b[0] == $past(CASC_B_I)
	) else $error("Row 0 did not take the cascade input");

	lane_clear_a: assert property (
		st_reg.clr_s2[2] |=> st_reg.res[2] == '0 && st_reg.a[2] == '0
	) else $error("Row 2 not cleared");

	lane_hold_a: assert property (
		!row_go[3] && !st_reg.clr_s2[3] |=> $stable(st_reg.a[3]) && $stable(st_reg.res[3])
	) else $error("Row 3 changed without a step");

	tick_pulse_a: assert property (
		tick[0] |-> $past(LANE_CLOCK_I[0], 2) && !$past(LANE_CLOCK_I[0], 3)
	) else $error("Row step not from a lane clock rising edge");

	wide_mode_a: assert property (
		is36 && row_go[1] && !st_reg.clr_s2[1] |=> st_reg.res[1] == $past(p74[2*ROWW-1:ROWW])
	) else $error("Wide product high half wrong");

	no_acc36_a: assert property (
		is36 |-> mode_lo == MODE_SIMPLE && mode_hi == MODE_SIMPLE && comp[3] == '0
	) else $error("Arithmetic stage active in wide mode");

	mac_size_a: assert property (
		mode_lo == MODE_MAC |-> size_lo == SIZE_18
	) else $error("Accumulate outside 18x18 size");

	cfg_write_a: assert property (
		apb_wr |=> st_reg.cfg == $past(PWDATA_I[7:0]) ##1 (st_reg.cfg == $past(st_reg.cfg) || $past(apb_wr))
	) else $error("Configuration write lost");
endmodule : dmac_block

// file: dmac_fab_model.sv
// Fabric-side model that pulses the per-row lane clocks of the block
`timescale 1ns/100ps
module dmac_fab_model (
	// System clock
	input  wire logic       clk_i,
	// Lane clocks toward the block
	output logic      [3:0] lane_clock_o
);
	// Lane clocks stand low outside steps
	initial lane_clock_o = 4'h0;
	// One row step; high and low last 4 cycles each, so the synchroniser never misses an edge
	task automatic step(input logic [3:0] rows);
		@(posedge clk_i);
		lane_clock_o <= rows;
		repeat (4) @(posedge clk_i);
		lane_clock_o <= 4'h0;
		repeat (4) @(posedge clk_i);
	endtask : step
endmodule : dmac_fab_model

// file: tb_top.sv
// Self-checking bench for the multiply-accumulate block
`timescale 1ns/100ps
`define CHK(nm, ex, ac) begin total_checks++; if ((ac) !== (ex)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, ex, ac); end end
module tb_top;
	import dmac_pkg::*;
	logic                     clk, rst_n, psel, pen, pwr, pready, pslverr, er;
	logic                     sa, sb, msl, msh, asl, ash, rl, sl, rh, sh, ldl, ldh;
	logic [AW-1:0]            paddr;
	logic [DW-1:0]            pwdata, prdata, rd;
	logic [3:0]               lclk, clr, en, srca, srcb;
	logic [3:0][OPW-1:0]      opa, opb;
	logic [OPW-1:0]           ca, cb, cao, cbo;
	logic [3:0][ROWW-1:0]     res, ex;
	logic [71:0]              p72;
	int                       err_count, total_checks;
	// Free-running system clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	dmac_fab_model fab (.clk_i(clk), .lane_clock_o(lclk));
	dmac_block dut (
		.SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.LANE_CLOCK_I(lclk), .LANE_ASYNC_CLEAR_I(clr), .LANE_CLK_ENABLE_I(en),
		.OPERAND_A_SIGNED_I(sa), .OPERAND_B_SIGNED_I(sb), .UNIT_MODE_SEL_LO_I(msl), .UNIT_MODE_SEL_HI_I(msh),
		.ADD_SUB_SEL_LO_I(asl), .ADD_SUB_SEL_HI_I(ash), .PAIR_LO_ROUND_I(rl), .PAIR_LO_SATURATE_I(sl),
		.PAIR_HI_ROUND_I(rh), .PAIR_HI_SATURATE_I(sh), .ACC_SYNC_LOAD_LO_I(ldl), .ACC_SYNC_LOAD_HI_I(ldh),
		.INPUT_A_SOURCE_SEL_I(srca), .INPUT_B_SOURCE_SEL_I(srcb), .OPERAND_A_I(opa), .OPERAND_B_I(opb),
		.CASC_A_I(ca), .CASC_B_I(cb), .ROW_RESULT_O(res), .CASC_A_O(cao), .CASC_B_O(cbo)
	);
	// Verdict and end of run, also reached when a wait runs out
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	// One APB transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
		int n;
		@(posedge clk);
		psel   <= 1'b1;
		pen    <= 1'b0;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb
	// Compare the selected row results against expectations
	task automatic chk_rows(input logic [3:0] m);
		for (int i = 0; i < 4; i++) if (m[i]) `CHK("row result", ex[i], res[i])
	endtask : chk_rows
	initial begin
		rst_n = 1'b0;
		{psel, pen, pwr, sa, sb, msl, msh, asl, ash, rl, sl, rh, sh, ldl, ldh} = '0;
		{paddr, pwdata, clr, srca, srcb, opa, opb, ca, cb} = '0;
		en = 4'hf;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// Registers: reset value, read back, read-only status, unmapped address
		apb(1'b0, CONFIG_OFS, 32'h0);
		`CHK("config reset", 32'h0, rd)
		apb(1'b0, 12'h008, 32'h0);
		`CHK("unmapped error", 1'b1, er)
		msl <= 1'b1;
		apb(1'b1, CONFIG_OFS, 32'h5);
		apb(1'b1, STATUS_OFS, 32'hff);
		apb(1'b0, CONFIG_OFS, 32'h0);
		`CHK("config", 32'h5, rd)
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("status", 32'h4, rd & 32'hfffffffc)
		$display("test registers done");
		// Eight 9x9 unsigned lanes
		msl <= 1'b0;
		apb(1'b1, CONFIG_OFS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			opa[i] <= {9'(i + 1), 9'h003};
			opb[i] <= {9'h1ff, 9'(i + 5)};
			ex[i] = {18'((i + 1) * 511), 18'(3 * (i + 5))};
		end
		fab.step(4'hf);
		fab.step(4'hf);
		chk_rows(4'hf);
		$display("test simple 9x9 done");
		// Signed 18x18 with rounding on the low half and saturation on the high half
		apb(1'b1, CONFIG_OFS, 32'h44);
		{sa, sb, rl, sh} <= 4'hf;
		opa <= {18'h20001, 18'h1ffff, 18'h00001, 18'h00003};
		opb <= {18'h1ffff, 18'h1ffff, 18'h03fff, 18'h02000};
		ex = {36'hfc0000000, 36'h03fff8000, 36'h0, 36'h8000};
		fab.step(4'hf);
		fab.step(4'hf);
		chk_rows(4'hf);
		$display("test simple 18x18 done");
		// One 36x36 product, unsigned then mixed sign with accumulate asked for
		{sa, sb, rl, sh} <= 4'h0;
		opa <= {18'h00007, 18'h00009, 18'h20002, 18'h3ffff};
		opb <= {18'h00003, 18'h00004, 18'h00001, 18'h00005};
		for (int k = 0; k < 2; k++) begin
			msl <= k[0];
			sa  <= k[0];
			apb(1'b1, CONFIG_OFS, 32'h8 + k);
			p72 = {k[0] ? 36'hfffffffff : 36'h0, 18'h20002, 18'h3ffff} * {36'h0, 18'h00001, 18'h00005};
			ex = {36'h0, 36'h0, p72[71:36], p72[35:0]};
			fab.step(4'hf);
			fab.step(4'hf);
			chk_rows(4'hf);
		end
		$display("test 36x36 done");
		// Low half sums two 18x18 products while the high half runs 9x9 simple
		sa  <= 1'b0;
		opa <= {18'h3ffff, {9'h2, 9'h3}, 18'd7, 18'd100};
		opb <= {18'h3ffff, {9'h4, 9'h5}, 18'd9, 18'd200};
		apb(1'b1, CONFIG_OFS, 32'h6);
		for (int k = 0; k < 2; k++) begin
			asl <= !k[0];
			ex = {{18'h3fc01, 18'h3fc01}, {18'd8, 18'd15}, 36'h0, 36'(k ? 19937 : 20063)};
			fab.step(4'hf);
			fab.step(4'hf);
			chk_rows(4'hf);
		end
		$display("test two-adder done");
		// Accumulate with sync load, add and subtract; zero operands let the result settle
		apb(1'b1, CONFIG_OFS, 32'h5);
		for (int k = 0; k < 11; k++) begin
			opa[0] <= (k < 3) ? 18'd3 : (k == 6 || k == 7) ? 18'd5 : 18'd0;
			opb[0] <= (k < 3) ? 18'd4 : (k == 6 || k == 7) ? 18'd10 : 18'd0;
			ldl    <= (k < 2);
			asl    <= (k < 6);
			fab.step(4'h3);
			if (k == 5) `CHK("acc sum", 36'd36, res[0])
		end
		ex = {36'h0, 36'h0, 36'hfffffffff, 36'hfffffffc0};
		chk_rows(4'h3);
		$display("test accumulate done");
		// Operand registers shift down the chain and leave the block
		msl  <= 1'b0;
		srca <= 4'hf;
		srcb <= 4'hf;
		apb(1'b1, CONFIG_OFS, 32'h44);
		for (int k = 0; k < 4; k++) begin
			ca <= 18'h100 + 18'(k);
			cb <= 18'h200 + 18'(k);
			fab.step(4'hf);
		end
		`CHK("chain a out", 18'h100, cao)
		`CHK("chain b out", 18'h200, cbo)
		$display("test chain done");
		// Disabled row keeps its result; cleared rows drop operands and result
		{srca, srcb, opa, opb} <= '0;
		en <= 4'b1011;
		fab.step(4'hf);
		ex = {36'h0, 36'h20000, 36'(18'h102 * 18'h202), 36'(18'h103 * 18'h203)};
		chk_rows(4'h7);
		clr <= 4'b1110;
		repeat (6) @(posedge clk);
		clr <= 4'h0;
		repeat (4) @(posedge clk);
		ex[2:1] = '0;
		chk_rows(4'h7);
		`CHK("cleared chain", 18'h0, cao)
		$display("test enable and clear done");
		// High half accumulates with rounding and sync load; low half saturates its products
		en  <= 4'hf;
		{msh, ash, rh, sl} <= 4'hf;
		opa <= {18'd0, 18'd3, 18'd2, 18'h1ffff};
		opb <= {18'd0, 18'h02000, 18'd3, 18'h1ffff};
		apb(1'b1, CONFIG_OFS, 32'h54);
		for (int k = 0; k < 3; k++) begin
			ldh <= (k < 2);
			fab.step(4'hf);
		end
		ex = {36'h0, 36'h10000, 36'd6, 36'h03fff8000};
		chk_rows(4'hf);
		apb(1'b0, STATUS_OFS, 32'h0);
		`CHK("status flags", 32'h11, rd)
		$display("test high accumulate done");
		// Four products summed onto rows 0 and 1, high pair subtracted then added
		{msh, rh, sl} <= 3'h0;
		{msl, asl} <= 2'h3;
		opa <= {18'd6, 18'd5, 18'd4, 18'd3};
		opb <= {4{18'd2}};
		apb(1'b1, CONFIG_OFS, 32'h7);
		for (int k = 0; k < 2; k++) begin
			ash <= k[0];
			ex = {108'h0, 36'(k ? 36 : 12)};
			fab.step(4'hf);
			fab.step(4'hf);
			chk_rows(4'hf);
		end
		$display("test four-adder done");
		tally_and_finish();
	end
endmodule : tb_top
